// >>> verification/tsf_host.sv
// Purpose: host side that reads the binary sample stream
// Assumes: one sample per sample_valid pulse
// Notes: bytes are taken most significant first, as a serial host would
`timescale 1ns/100ps
module tsf_host (
  // stream from the formatter
  input wire logic mclk,
  input wire logic sample_valid,
  input wire logic [79:0] sample_data,
  // decoded fields
  output logic [15:0] isw,
  output logic [31:0] tval,
  output logic [31:0] ecnt,
  output logic [15:0] n_samp
);
  logic [7:0] bytes [10];
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      bytes[i] = sample_data[79 - 8 * i -: 8];
    end
  end
  initial n_samp = 16'h0000;
  always @(posedge mclk) begin
    if (sample_valid === 1'b1) begin
      isw <= {bytes[0], bytes[1]};
      tval <= {bytes[2], bytes[3], bytes[4], bytes[5]};
      ecnt <= {bytes[6], bytes[7], bytes[8], bytes[9]};
      n_samp <= n_samp + 16'h0001;
    end
  end
endmodule : tsf_host

// >>> verification/tsf_top_bench.sv
// Purpose: self-checking bench for the sample formatter
// Assumes: pin strobes last 3 cycles so the 2-flop syncs see them
// Notes: samples are read back through the host model
`timescale 1ns/100ps
module tsf_top_bench;
  import tsf_pkg::*;
  logic mclk = 1'b0;
  logic resetn;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, t1, e1;
  logic event_in, sample_in, block_arm_in, pretrig_in, inhibit_in, er, got;
  logic [4:0] interp_in;
  logic [79:0] sample_data;
  logic sample_valid, pretrig_seen;
  logic [15:0] isw, n_samp, n0;
  logic [31:0] tval, ecnt;
  int failures = 0;
  int n_compared = 0;
  always #10 mclk = ~mclk;
  tsf_top i_tsf_top (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .sample_in(sample_in),
    .block_arm_in(block_arm_in), .pretrig_in(pretrig_in), .inhibit_in(inhibit_in),
    .interp_in(interp_in), .sample_data(sample_data), .sample_valid(sample_valid),
    .pretrig_seen(pretrig_seen));
  tsf_host i_tsf_host (.mclk(mclk), .sample_valid(sample_valid), .sample_data(sample_data),
    .isw(isw), .tval(tval), .ecnt(ecnt), .n_samp(n_samp));
  //////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      print_verdict();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  // k: 0 sample, 1 event, 2 block arm, 3 pretrigger
  task strobe(input int k);
    @(posedge mclk);
    case (k)
      0: sample_in <= 1'b1;
      1: event_in <= 1'b1;
      2: block_arm_in <= 1'b1;
      default: pretrig_in <= 1'b1;
    endcase
    repeat (3) @(posedge mclk);
    {sample_in, event_in, block_arm_in, pretrig_in} <= 4'h0;
    repeat (3) @(posedge mclk);
  endtask : strobe
  // window is bounded; a missing sample is judged by the caller
  task take(output logic g);
    logic [15:0] n0;
    n0 = n_samp;
    strobe(0);
    repeat (12) @(posedge mclk);
    g = (n_samp !== n0);
  endtask : take
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, event_in, sample_in, block_arm_in} = 6'h00;
    {pretrig_in, inhibit_in} = 2'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    interp_in = 5'h07;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    apb(1'b0, TSF_CTRL_OFF, 32'h0);
    chk(rd, TSF_CTRL_RST);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test registers done");
    apb(1'b1, TSF_CTRL_OFF, 32'h1 << TSF_C_EN);
    strobe(2);
    take(got);
    chk({31'h0, got}, 32'h1);
    chk({31'h0, isw[TSF_BLK_BIT]}, 32'h1);
    chk({27'h0, isw[4:0]}, 32'h6);
    t1 = tval;
    e1 = ecnt;
    interp_in <= 5'h1f;
    repeat (3) strobe(1);
    take(got);
    chk({31'h0, isw[TSF_BLK_BIT]}, 32'h0);
    chk({27'h0, isw[4:0]}, TSF_INTERP_MAX);
    chk(ecnt - e1, 32'h3);
    chk({31'h0, tval > t1}, 32'h1);
    $display("test samples done");
    inhibit_in <= 1'b1;
    strobe(3);
    take(got);
    chk({31'h0, got}, 32'h0);
    chk({31'h0, pretrig_seen}, 32'h1);
    inhibit_in <= 1'b0;
    take(got);
    chk({31'h0, got}, 32'h1);
    chk({31'h0, isw[TSF_INH_BIT]}, 32'h1);
    take(got);
    chk({31'h0, isw[TSF_INH_BIT]}, 32'h0);
    $display("test inhibit done");
    apb(1'b1, TSF_CTRL_OFF, 32'h3b);
    take(got);
    chk({tval[31:16], ecnt[31:16]}, 32'h0);
    chk({30'h0, isw[TSF_TVB_BIT:TSF_TVA_BIT]}, 32'h3);
    apb(1'b1, TSF_CTRL_OFF, 32'h19);
    take(got);
    chk({30'h0, isw[TSF_TVB_BIT:TSF_TVA_BIT]}, 32'h1);
    $display("test fast totalize done");
    apb(1'b1, TSF_CTRL_OFF, 32'h41);
    t1 = tval;
    n0 = n_samp;
    inhibit_in <= 1'b1;
    strobe(2);
    repeat (12) @(posedge mclk);
    chk({16'h0, n_samp - n0}, 32'h1);
    chk({31'h0, isw[TSF_BLK_BIT]}, 32'h1);
    chk(ecnt, 32'h0);
    chk({31'h0, tval > t1}, 32'h1);
    inhibit_in <= 1'b0;
    take(got);
    chk({31'h0, got}, 32'h1);
    chk({31'h0, isw[TSF_BLK_BIT]}, 32'h0);
    $display("test arm sample done");
    apb(1'b1, TSF_CTRL_OFF, 32'h05);
    n0 = n_samp;
    take(got);
    chk({31'h0, got}, 32'h0);
    take(got);
    chk({16'h0, n_samp - n0}, 32'h2);
    chk({31'h0, isw[TSF_BLK_BIT]}, 32'h0);
    n0 = n_samp;
    take(got);
    inhibit_in <= 1'b1;
    repeat (4) @(posedge mclk);
    inhibit_in <= 1'b0;
    take(got);
    chk({16'h0, n_samp - n0}, 32'h0);
    take(got);
    chk({16'h0, n_samp - n0}, 32'h2);
    $display("test pairs done");
    apb(1'b1, TSF_CTRL_OFF, 32'h81);
    apb(1'b1, TSF_STAT_OFF, 32'h0);
    @(posedge mclk);
    chk({31'h0, pretrig_seen}, 32'h0);
    inhibit_in <= 1'b1;
    strobe(3);
    chk({31'h0, pretrig_seen}, 32'h0);
    inhibit_in <= 1'b0;
    strobe(3);
    chk({31'h0, pretrig_seen}, 32'h1);
    $display("test interval pretrigger done");
    print_verdict();
  end
endmodule : tsf_top_bench

// >>> verilog/tsf_pkg.sv
// Purpose: shared constants for the timestamp sample formatter
// Assumes: 50 MHz bus clock, APB register access
// Notes: one aligned 32-bit word per register
package tsf_pkg;
  localparam logic [11:0] TSF_CTRL_OFF = 12'h000;
  localparam logic [11:0] TSF_STAT_OFF = 12'h004;
  localparam logic [11:0] TSF_TIME_OFF = 12'h008;
  localparam logic [11:0] TSF_EVNT_OFF = 12'h00c;
  localparam logic [11:0] TSF_ISW_OFF = 12'h010;
  localparam logic [11:0] TSF_CNT_OFF = 12'h014;
  localparam logic [31:0] TSF_CTRL_RST = 32'h0000_0000;
  localparam int TSF_INTERP_MAX = 18;
  localparam int TSF_CLK_MHZ = 50;
  localparam int TSF_FAST_MIN_NS = 75;
  localparam int TSF_FAST_MIN_CYC = (TSF_FAST_MIN_NS * TSF_CLK_MHZ + 999) / 1000;
  localparam int TSF_NORM_MIN_CYC = 1;
  // status word bit positions
  localparam int TSF_INH_BIT = 5;
  localparam int TSF_BLK_BIT = 6;
  localparam int TSF_TVA_BIT = 13;
  localparam int TSF_TVB_BIT = 14;
  // control bit positions
  localparam int TSF_C_EN = 0;
  localparam int TSF_C_FAST = 1;
  localparam int TSF_C_PAIR = 2;
  localparam int TSF_C_TOT = 3;
  localparam int TSF_C_TVA = 4;
  localparam int TSF_C_TVB = 5;
  localparam int TSF_C_ARMX = 6;
  localparam int TSF_C_PTI = 7;
  localparam int TSF_C_BLK = 8;
  typedef enum logic [1:0] {TSF_IDLE, TSF_FIRST, TSF_SECOND} tsf_state_t;
endpackage : tsf_pkg

// >>> verilog/tsf_top.sv
// Purpose: captures time and event counts into 80-bit samples for the host
// Assumes: event, trigger, arm and inhibit pins are asynchronous to mclk
// Notes: counters wrap silently; host reads the newest sample over APB
// How it works
// - inhibit stops sample collection until released
// - arming and block-arm time capture ignore inhibit
// - pretrigger edges seen; measurements wait for release
// - interval pretrigger monitoring suspended during inhibit
// - pairs with an inhibited sample discarded whole
// - inhibit stretches gap or gate only
// - block-arm trigger gives first time datum
// - block-arm sample event field meaningless
// - 16-bit status word, high byte first
// - bits 4..0 hold interpolator, 0 to 18
// - interpolator counts even 100 ps steps
// - bit 5 flags inhibit-discarded samples
// - bit 6 marks first sample of block
// - totalize bits choose valid attempt
// - totalize flags used only in their formats
// - fast mode shrinks time/event fields to 16
// - fast mode minimum sample interval 75 ns
// - fast event counter wraps at 65,536
// - fast time counter wraps at 1310.72 us
// - time counter counts time base continuously
// - normal fields 32-bit, high byte first
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
module tsf_top
  import tsf_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement pins
  input wire logic event_in,
  input wire logic sample_in,
  input wire logic block_arm_in,
  input wire logic pretrig_in,
  input wire logic inhibit_in,
  input wire logic [4:0] interp_in,
  // sample stream
  output logic [79:0] sample_data,
  output logic sample_valid,
  output logic pretrig_seen
);
  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] s1, s2, s3;
  logic [31:0] ctrl;
  logic [31:0] time_cnt, event_cnt;
  logic [31:0] cap_time, cap_event;
  logic [15:0] cap_isw;
  logic [31:0] sample_cnt;
  logic [7:0] gap_cnt;
  logic [4:0] interp_s1, interp_s2;
  logic blk_pend, inh_lost, ptc_armed;
  tsf_state_t state;
  logic ev_r, sm_r, ba_r, pt_r, inh;
  logic ev_edge, sm_edge, ba_edge, pt_edge;
  logic [31:0] first_time, first_event;
  logic [31:0] stop_time, stop_event;
  // start and stop halves are held until both are known good
  logic [15:0] first_isw, stop_isw;
  logic stop_pend;

  // two-stage synchronisers; the second stage and a third edge-detect stage feed logic
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
      interp_s1 <= 5'h00;
      interp_s2 <= 5'h00;
    end else begin
      s1 <= {inhibit_in, pretrig_in, block_arm_in, sample_in, event_in};
      s2 <= s1;
      s3 <= s2;
      interp_s1 <= interp_in;
      interp_s2 <= interp_s1;
    end
  end
  assign {inh, pt_r, ba_r, sm_r, ev_r} = s2;
  assign ev_edge = ev_r & ~s3[0];
  assign sm_edge = sm_r & ~s3[1];
  assign ba_edge = ba_r & ~s3[2];
  assign pt_edge = pt_r & ~s3[3];

  // interpolator: clamp to 18 and force even steps
  function automatic logic [4:0] tsf_interp(input logic [4:0] raw);
    logic [4:0] v;
    v = (raw > 5'(TSF_INTERP_MAX)) ? 5'(TSF_INTERP_MAX) : raw;
    return {v[4:1], 1'b0};
  endfunction : tsf_interp

  // narrow fields in fast mode
  function automatic logic [31:0] tsf_field(input logic [31:0] v, input logic fast);
    return fast ? {16'h0000, v[15:0]} : v;
  endfunction : tsf_field

  ////////////////////////////////////////////////////////////////////////////
  // free-running time counter and event-edge counter wrap silently
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      time_cnt <= 32'h0000_0000;
    end else begin
      time_cnt <= time_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      event_cnt <= 32'h0000_0000;
    end else if (ev_edge) begin
      event_cnt <= event_cnt + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pretrigger detection runs through inhibit except in interval mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pretrig_seen <= 1'b0;
    end else if (pt_edge && !(ctrl[TSF_C_PTI] && inh)) begin
      pretrig_seen <= 1'b1;
    end else if (psel && penable && pwrite && paddr == TSF_STAT_OFF) begin
      pretrig_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture engine
  logic fast, take, arm_take;
  logic [7:0] min_gap;
  assign fast = ctrl[TSF_C_FAST];
  assign min_gap = fast ? 8'(TSF_FAST_MIN_CYC) : 8'(TSF_NORM_MIN_CYC);
  assign take = ctrl[TSF_C_EN] && sm_edge && (gap_cnt == 8'h00);
  // arm sample is taken regardless of inhibit
  assign arm_take = ctrl[TSF_C_EN] && ctrl[TSF_C_ARMX] && ba_edge;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gap_cnt <= 8'h00;
    end else if (take && !inh) begin
      gap_cnt <= min_gap - 8'h01;
    end else if (gap_cnt != 8'h00) begin
      gap_cnt <= gap_cnt - 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blk_pend <= 1'b0;
    end else if (ba_edge && ctrl[TSF_C_EN]) begin
      blk_pend <= 1'b1;
    end else if (sample_valid) begin
      blk_pend <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      inh_lost <= 1'b0;
    end else if (take && inh) begin
      inh_lost <= 1'b1;
    end else if (state == TSF_FIRST && inh) begin
      inh_lost <= 1'b1;
    end else if (sample_valid) begin
      inh_lost <= 1'b0;
    end
  end

  logic [15:0] isw_now;
  always_comb begin
    isw_now = 16'h0000;
    isw_now[4:0] = tsf_interp(interp_s2);
    isw_now[TSF_INH_BIT] = inh_lost;
    isw_now[TSF_BLK_BIT] = blk_pend | arm_take;
    isw_now[TSF_TVA_BIT] = ctrl[TSF_C_TOT] & ctrl[TSF_C_TVA];
    isw_now[TSF_TVB_BIT] = ctrl[TSF_C_TOT] & ctrl[TSF_C_TVB];
  end

  // pair state: inhibit before the stop half is taken drops the pair
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= TSF_IDLE;
      first_time <= 32'h0000_0000;
      first_event <= 32'h0000_0000;
      first_isw <= 16'h0000;
      stop_time <= 32'h0000_0000;
      stop_event <= 32'h0000_0000;
      stop_isw <= 16'h0000;
    end else begin
      case (state)
        TSF_IDLE: begin
          if (take && !inh && ctrl[TSF_C_PAIR]) begin
            state <= TSF_FIRST;
            first_time <= tsf_field(time_cnt, fast);
            first_event <= tsf_field(event_cnt, fast);
            first_isw <= isw_now;
          end
        end
        TSF_FIRST: begin
          if (inh) begin
            state <= TSF_IDLE;
          end else if (take) begin
            // the stop half is never a block start and reports no loss
            state <= TSF_SECOND;
            stop_time <= tsf_field(time_cnt, fast);
            stop_event <= tsf_field(event_cnt, fast);
            stop_isw <= {isw_now[15:7], 2'b00, isw_now[4:0]};
          end
        end
        TSF_SECOND: begin
          state <= TSF_IDLE;
        end
        default: begin
          state <= TSF_IDLE;
        end
      endcase
    end
  end

  // stop half leaves one cycle after the start half
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stop_pend <= 1'b0;
    end else begin
      stop_pend <= (state == TSF_SECOND);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output sample register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cap_time <= 32'h0000_0000;
      cap_event <= 32'h0000_0000;
      cap_isw <= 16'h0000;
      sample_valid <= 1'b0;
      sample_data <= 80'h0;
      sample_cnt <= 32'h0000_0000;
    end else begin
      sample_valid <= 1'b0;
      // a finished pair goes out first; an arm sample that lands in those two
      // cycles is lost, which keeps the pair whole
      if (state == TSF_SECOND) begin
        cap_time <= first_time;
        cap_event <= first_event;
        cap_isw <= first_isw;
        sample_data <= {first_isw, first_time, first_event};
        sample_valid <= 1'b1;
        sample_cnt <= sample_cnt + 32'h0000_0001;
      end else if (stop_pend) begin
        cap_time <= stop_time;
        cap_event <= stop_event;
        cap_isw <= stop_isw;
        sample_data <= {stop_isw, stop_time, stop_event};
        sample_valid <= 1'b1;
        sample_cnt <= sample_cnt + 32'h0000_0001;
      end else if (arm_take && !(take && !inh)) begin
        cap_time <= tsf_field(time_cnt, fast);
        cap_event <= 32'h0000_0000;
        cap_isw <= isw_now;
        sample_data <= {isw_now, tsf_field(time_cnt, fast), 32'h0000_0000};
        sample_valid <= 1'b1;
        sample_cnt <= sample_cnt + 32'h0000_0001;
      end else if (take && !inh && !ctrl[TSF_C_PAIR]) begin
        cap_time <= tsf_field(time_cnt, fast);
        cap_event <= tsf_field(event_cnt, fast);
        cap_isw <= isw_now;
        sample_data <= {isw_now, tsf_field(time_cnt, fast), tsf_field(event_cnt, fast)};
        sample_valid <= 1'b1;
        sample_cnt <= sample_cnt + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= TSF_CTRL_RST;
    end else if (psel && penable && pwrite && paddr == TSF_CTRL_OFF) begin
      ctrl <= pwdata;
    end
  end

  logic addr_ok;
  assign addr_ok = (paddr == TSF_CTRL_OFF) || (paddr == TSF_STAT_OFF) ||
                   (paddr == TSF_TIME_OFF) || (paddr == TSF_EVNT_OFF) ||
                   (paddr == TSF_ISW_OFF) || (paddr == TSF_CNT_OFF);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          TSF_CTRL_OFF: prdata <= ctrl;
          TSF_STAT_OFF: prdata <= {27'h0, inh, blk_pend, inh_lost, state != TSF_IDLE,
                                   pretrig_seen};
          TSF_TIME_OFF: prdata <= cap_time;
          TSF_EVNT_OFF: prdata <= cap_event;
          TSF_ISW_OFF: prdata <= {16'h0000, cap_isw};
          TSF_CNT_OFF: prdata <= sample_cnt;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  no_inh_sample_a: assert property (@(posedge mclk) disable iff (!resetn)
    (take && inh && !arm_take && state == TSF_IDLE && !stop_pend) |=> !sample_valid)
    else $error("sample taken under inhibit");
  arm_capture_a: assert property (@(posedge mclk) disable iff (!resetn)
    (arm_take && state != TSF_SECOND && !stop_pend) |=>
      sample_valid && sample_data[15:0] == 16'h0000)
    else $error("arm sample missing");
  arm_blkbit_a: assert property (@(posedge mclk) disable iff (!resetn)
    (arm_take && state != TSF_SECOND && !stop_pend) |=>
      sample_data[64 + TSF_BLK_BIT])
    else $error("block bit clear on arm");
  interp_even_a: assert property (@(posedge mclk) disable iff (!resetn)
    sample_valid |-> !sample_data[64] && sample_data[68:64] <= 5'h12)
    else $error("bad interpolator");
  fast_width_a: assert property (@(posedge mclk) disable iff (!resetn)
    (sample_valid && $past(fast)) |-> sample_data[63:48] == 16'h0000)
    else $error("fast field too wide");
  fast_event_a: assert property (@(posedge mclk) disable iff (!resetn)
    (sample_valid && $past(fast)) |-> sample_data[31:16] == 16'h0000)
    else $error("fast event field too wide");
  fast_gap_a: assert property (@(posedge mclk) disable iff (!resetn)
    (take && !inh && fast) |=> gap_cnt == 8'(TSF_FAST_MIN_CYC - 1))
    else $error("fast gap wrong");
  pair_drop_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state == TSF_FIRST && inh) |=> state == TSF_IDLE)
    else $error("pair kept under inhibit");
  pair_whole_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == TSF_SECOND |=> sample_valid ##1 sample_valid)
    else $error("pair not delivered whole");
  pair_stop_a: assert property (@(posedge mclk) disable iff (!resetn)
    stop_pend |=> sample_valid && !sample_data[64 + TSF_BLK_BIT])
    else $error("block bit on stop half");
  time_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
    time_cnt == 32'hffff_ffff |=> time_cnt == 32'h0000_0000)
    else $error("time counter wrap");
  event_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
    (event_cnt == 32'hffff_ffff && ev_edge) |=> event_cnt == 32'h0000_0000)
    else $error("event counter wrap");
  inh_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
    (take && inh) |=> inh_lost)
    else $error("inhibit flag not set");
  tot_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
    !ctrl[TSF_C_TOT] |-> !isw_now[TSF_TVA_BIT] && !isw_now[TSF_TVB_BIT])
    else $error("totalize flag outside totalize");
  pretrig_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    (pt_edge && !ctrl[TSF_C_PTI]) |=> pretrig_seen)
    else $error("pretrig edge missed");
  pretrig_int_a: assert property (@(posedge mclk) disable iff (!resetn)
    (pt_edge && ctrl[TSF_C_PTI] && inh && !pretrig_seen) |=> !pretrig_seen)
    else $error("pretrig seen under inhibit");
endmodule : tsf_top
